// ---- hdl/rsf_defines.vh ----
`ifndef RSF_DEFINES_VH
`define RSF_DEFINES_VH

// ==========================================================
// register offsets
`define RSF_ADDR_RATE_X0   7'h08
`define RSF_ADDR_RATE_X1   7'h09
`define RSF_ADDR_RATE_Y0   7'h0A
`define RSF_ADDR_RATE_Y1   7'h0B
`define RSF_ADDR_POWER     7'h10
`define RSF_ADDR_FILTER    7'h11

// ==========================================================
// fields and reset values
`define RSF_MEAS_BIT       1
`define RSF_TSM_BIT        0
`define RSF_HP_MSB         7
`define RSF_HP_LSB         4
`define RSF_LP_MSB         2
`define RSF_LP_LSB         0
`define RSF_POWER_RST      8'h00
`define RSF_FILTER_RST     8'h00
`define RSF_HP_ALLPASS     4'h0
`define RSF_HP_LAST_CODE   4'hA

// ==========================================================
// timing
`define RSF_SYS_HZ         100000000
`define RSF_PDM_HZ         144000
`define RSF_PDM_DIV        (`RSF_SYS_HZ / `RSF_PDM_HZ)
`define RSF_SETTLE_MS      100
`define RSF_PDM_LAST       10'h2B5
`define RSF_SETTLE_CYC     24'h989680
`define RSF_HP_FAST_SH     5'd5

`endif

// ---- hdl/rsf_sync3.v ----
`default_nettype none

// ==========================================================
// three-stage synchroniser, level taken once stages two and three agree
module rsf_sync3 #(
	parameter         W       = 1,
	parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
	input  wire         clk_sys,
	input  wire         rst_b,
	input  wire [W-1:0] async_in,
	output reg  [W-1:0] level_q
);

	reg [W-1:0] s1_q;
	reg [W-1:0] s2_q;
	reg [W-1:0] s3_q;

	always @(posedge clk_sys) begin
		if (!rst_b) begin
			s1_q    <= RST_VAL;
			s2_q    <= RST_VAL;
			s3_q    <= RST_VAL;
			level_q <= RST_VAL;
		end else begin
			s1_q    <= async_in;
			s2_q    <= s1_q;
			s3_q    <= s2_q;
			level_q <= (s2_q & ~(s2_q ^ s3_q)) | (level_q & (s2_q ^ s3_q));
		end
	end

endmodule // rsf_sync3

`default_nettype wire

// ---- hdl/rsf_pdm.v ----
`default_nettype none

// ==========================================================
// first-order pulse-density modulator, one bit per tick
module rsf_pdm (
	input  wire        clk_sys,
	input  wire        rst_b,
	input  wire        tick,
	input  wire        enable,
	input  wire [15:0] sample,
	output reg         bit_q
);

	reg  [15:0] acc_q;
	wire [16:0] sum;

	// offset binary: midscale is zero rate
	assign sum = {1'b0, acc_q} + {1'b0, sample ^ 16'h8000};

	always @(posedge clk_sys) begin
		if (!rst_b) begin
			acc_q <= 16'h0000;
			bit_q <= 1'b0;
		end else if (!enable) begin
			acc_q <= 16'h0000;
			bit_q <= 1'b0;
		end else if (tick) begin
			acc_q <= sum[15:0];
			bit_q <= sum[16];
		end
	end

endmodule // rsf_pdm

`default_nettype wire

// ---- hdl/rsf_top.v ----
`include "rsf_defines.vh"
`default_nettype none

// ==========================================================
// serial register port, mode control and band-pass filter
module rsf_top #(
	parameter [23:0] SETTLE_CYCLES = `RSF_SETTLE_CYC
) (
	input  wire        clk_sys,
	input  wire        rst_b,
	input  wire        spi_sclk,
	input  wire        spi_cs_b,
	input  wire        spi_mosi,
	output wire        spi_miso,
	output wire        spi_miso_oe,
	input  wire        interface_supply,
	input  wire        analog_mode_sel,
	input  wire        sample_valid,
	input  wire [15:0] sample_x,
	input  wire [15:0] sample_y,
	output reg  [15:0] rate_x_out,
	output reg  [15:0] rate_y_out,
	output reg         rate_update,
	output reg         measuring,
	output reg         offset_settled,
	output reg         temp_sensor_en,
	output wire        density_stream_out_x,
	output wire        density_stream_out_y
);

	// ==========================================================
	// local constants
	localparam [1:0] ST_IDLE  = 2'd0;
	localparam [1:0] ST_HDR   = 2'd1;
	localparam [1:0] ST_DATA  = 2'd2;
	localparam [1:0] ST_BLOCK = 2'd3;
	localparam [9:0] PDM_LAST = `RSF_PDM_LAST;

	// ==========================================================
	// functions
	function [3:0] lp_shift;
		input [2:0] code;
		begin
			case (code)
				3'd0:    lp_shift = 4'd1;
				3'd1:    lp_shift = 4'd2;
				3'd2:    lp_shift = 4'd3;
				3'd3:    lp_shift = 4'd4;
				3'd4:    lp_shift = 4'd5;
				3'd5:    lp_shift = 4'd6;
				3'd6:    lp_shift = 4'd7;
				default: lp_shift = 4'd8;
			endcase
		end
	endfunction

	// zero means no high-pass tracking
	function [4:0] hp_shift;
		input [3:0] code;
		begin
			case (code)
				4'h1:    hp_shift = 5'd15;
				4'h2:    hp_shift = 5'd14;
				4'h3:    hp_shift = 5'd13;
				4'h4:    hp_shift = 5'd12;
				4'h5:    hp_shift = 5'd11;
				4'h6:    hp_shift = 5'd10;
				4'h7:    hp_shift = 5'd9;
				4'h8:    hp_shift = 5'd8;
				4'h9:    hp_shift = 5'd7;
				4'hA:    hp_shift = 5'd5;
				default: hp_shift = 5'd0;
			endcase
		end
	endfunction

	function signed [23:0] iir_step;
		input signed [23:0] st;
		input signed [23:0] tgt;
		input        [4:0]  sh;
		reg   signed [24:0] diff;
		reg   signed [24:0] part;
		reg   signed [24:0] sum;
		begin
			diff     = tgt - st;
			part     = diff >>> sh;
			sum      = st + part;
			iir_step = sum[23:0];
		end
	endfunction

	// ==========================================================
	// pin synchronisers
	wire [4:0] pins_lvl;
	wire       sclk_lvl;
	wire       cs_b_lvl;
	wire       mosi_lvl;
	wire       supply_lvl;
	wire       analog_lvl;

	rsf_sync3 #(
		.W       (5),
		.RST_VAL (5'b00011)
	) u_sync (
		.clk_sys  (clk_sys),
		.rst_b    (rst_b),
		.async_in ({analog_mode_sel, interface_supply, spi_mosi, spi_cs_b, spi_sclk}),
		.level_q  (pins_lvl)
	);

	assign sclk_lvl   = pins_lvl[0];
	assign cs_b_lvl   = pins_lvl[1];
	assign mosi_lvl   = pins_lvl[2];
	assign supply_lvl = pins_lvl[3];
	assign analog_lvl = pins_lvl[4];

	// ==========================================================
	// serial clock edges
	reg  sclk_prev_q;
	wire sclk_rise;
	wire sclk_fall;
	wire cs_active;

	always @(posedge clk_sys) begin
		if (!rst_b) begin
			sclk_prev_q <= 1'b1;
		end else begin
			sclk_prev_q <= sclk_lvl;
		end
	end

	assign sclk_rise = sclk_lvl & ~sclk_prev_q;
	assign sclk_fall = ~sclk_lvl & sclk_prev_q;
	assign cs_active = ~cs_b_lvl & supply_lvl;

	// ==========================================================
	// registers
	reg [7:0]         power_q;
	reg [7:0]         filter_q;
	reg signed [23:0] lpx_q;
	reg signed [23:0] lpy_q;
	reg signed [23:0] estx_q;
	reg signed [23:0] esty_q;
	reg [23:0]        settle_cnt_q;

	function [7:0] rd_mux;
		input [6:0] addr;
		begin
			case (addr)
				`RSF_ADDR_RATE_X0: rd_mux = rate_x_out[7:0];
				`RSF_ADDR_RATE_X1: rd_mux = rate_x_out[15:8];
				`RSF_ADDR_RATE_Y0: rd_mux = rate_y_out[7:0];
				`RSF_ADDR_RATE_Y1: rd_mux = rate_y_out[15:8];
				`RSF_ADDR_POWER:   rd_mux = power_q;
				`RSF_ADDR_FILTER:  rd_mux = filter_q;
				default:           rd_mux = 8'h00;
			endcase
		end
	endfunction

	// ==========================================================
	// serial transfer engine
	reg [1:0] state_q;
	reg [2:0] bit_cnt_q;
	reg [7:0] shift_q;
	reg [7:0] tx_q;
	reg       rw_q;
	reg [6:0] addr_q;
	reg       load_q;
	reg       miso_q;
	reg       miso_oe_q;
	reg       wr_en_q;
	reg [6:0] wr_addr_q;
	reg [7:0] wr_data_q;
	wire [7:0] byte_in;

	assign byte_in     = {shift_q[6:0], mosi_lvl};
	assign spi_miso    = miso_q;
	assign spi_miso_oe = miso_oe_q;

	always @(posedge clk_sys) begin
		if (!rst_b) begin
			state_q   <= ST_IDLE;
			bit_cnt_q <= 3'd0;
			shift_q   <= 8'h00;
			tx_q      <= 8'h00;
			rw_q      <= 1'b0;
			addr_q    <= 7'h00;
			load_q    <= 1'b0;
			miso_q    <= 1'b0;
			miso_oe_q <= 1'b0;
			wr_en_q   <= 1'b0;
			wr_addr_q <= 7'h00;
			wr_data_q <= 8'h00;
		end else begin
			wr_en_q <= 1'b0;
			load_q  <= 1'b0;
			if (load_q) begin
				tx_q <= rd_mux(addr_q);
			end
			if (!cs_active) begin
				state_q   <= ST_IDLE;
				miso_oe_q <= 1'b0;
				miso_q    <= 1'b0;
				bit_cnt_q <= 3'd0;
			end else begin
				miso_oe_q <= 1'b1;
				case (state_q)
					ST_IDLE: begin
						bit_cnt_q <= 3'd0;
						state_q   <= ST_HDR;
					end
					ST_HDR: begin
						if (sclk_fall) begin
							miso_q <= 1'b0;
						end
						if (sclk_rise) begin
							shift_q   <= byte_in;
							bit_cnt_q <= bit_cnt_q + 3'd1;
							if (bit_cnt_q == 3'd7) begin
								rw_q    <= byte_in[7];
								addr_q  <= byte_in[6:0];
								load_q  <= byte_in[7];
								state_q <= ST_DATA;
							end
						end
					end
					ST_DATA: begin
						if (sclk_fall) begin
							miso_q <= rw_q & tx_q[7];
							tx_q   <= {tx_q[6:0], 1'b0};
						end
						if (sclk_rise) begin
							shift_q   <= byte_in;
							bit_cnt_q <= bit_cnt_q + 3'd1;
							if (bit_cnt_q == 3'd7) begin
								wr_en_q   <= ~rw_q;
								wr_addr_q <= addr_q;
								wr_data_q <= byte_in;
								addr_q    <= addr_q + 7'h01;
								load_q    <= rw_q;
								if (!measuring) begin
									state_q <= ST_BLOCK;
								end
							end
						end
					end
					ST_BLOCK: begin
						if (sclk_fall) begin
							miso_q <= 1'b0;
						end
					end
					default: begin
						state_q <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// ==========================================================
	// control registers
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			power_q  <= `RSF_POWER_RST;
			filter_q <= `RSF_FILTER_RST;
		end else if (wr_en_q) begin
			if (wr_addr_q == `RSF_ADDR_POWER) begin
				power_q <= {6'b000000, wr_data_q[`RSF_MEAS_BIT], wr_data_q[`RSF_TSM_BIT]};
			end
			if (wr_addr_q == `RSF_ADDR_FILTER) begin
				filter_q <= {wr_data_q[`RSF_HP_MSB:`RSF_HP_LSB], 1'b0,
					wr_data_q[`RSF_LP_MSB:`RSF_LP_LSB]};
			end
		end
	end

	// ==========================================================
	// operating mode
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			measuring      <= 1'b0;
			temp_sensor_en <= 1'b0;
			offset_settled <= 1'b0;
			settle_cnt_q   <= 24'h000000;
		end else begin
			measuring      <= (power_q[`RSF_MEAS_BIT] & supply_lvl) | analog_lvl;
			temp_sensor_en <= power_q[`RSF_TSM_BIT] & measuring;
			if (!measuring) begin
				settle_cnt_q   <= 24'h000000;
				offset_settled <= 1'b0;
			end else if (settle_cnt_q == SETTLE_CYCLES) begin
				offset_settled <= 1'b1;
			end else begin
				settle_cnt_q <= settle_cnt_q + 24'h000001;
			end
		end
	end

	// ==========================================================
	// band-pass filter datapath
	wire [2:0]         lp_code;
	wire [3:0]         hp_code;
	wire               hp_valid;
	reg  [4:0]         hp_sh;
	reg  signed [23:0] lpx_d;
	reg  signed [23:0] lpy_d;
	reg  signed [23:0] estx_d;
	reg  signed [23:0] esty_d;
	reg  signed [23:0] outx;
	reg  signed [23:0] outy;

	assign lp_code  = filter_q[`RSF_LP_MSB:`RSF_LP_LSB];
	assign hp_code  = filter_q[`RSF_HP_MSB:`RSF_HP_LSB];
	assign hp_valid = (hp_code != `RSF_HP_ALLPASS) && (hp_code <= `RSF_HP_LAST_CODE);

	always @* begin
		// fast tracking until the settle window closes
		if (hp_valid && !offset_settled) begin
			hp_sh = `RSF_HP_FAST_SH;
		end else begin
			hp_sh = hp_shift(hp_code);
		end
		lpx_d  = iir_step(lpx_q, {sample_x, 8'h00}, {1'b0, lp_shift(lp_code)});
		lpy_d  = iir_step(lpy_q, {sample_y, 8'h00}, {1'b0, lp_shift(lp_code)});
		estx_d = estx_q;
		esty_d = esty_q;
		outx   = lpx_d;
		outy   = lpy_d;
		if (hp_sh != 5'd0) begin
			estx_d = iir_step(estx_q, lpx_d, hp_sh);
			esty_d = iir_step(esty_q, lpy_d, hp_sh);
			outx   = lpx_d - estx_d;
			outy   = lpy_d - esty_d;
		end
	end

	always @(posedge clk_sys) begin
		if (!rst_b) begin
			lpx_q       <= 24'sh000000;
			lpy_q       <= 24'sh000000;
			estx_q      <= 24'sh000000;
			esty_q      <= 24'sh000000;
			rate_x_out  <= 16'h0000;
			rate_y_out  <= 16'h0000;
			rate_update <= 1'b0;
		end else begin
			rate_update <= 1'b0;
			if (!measuring) begin
				estx_q <= 24'sh000000;
				esty_q <= 24'sh000000;
			end else if (sample_valid) begin
				rate_update <= 1'b1;
				if (analog_lvl) begin
					rate_x_out <= sample_x;
					rate_y_out <= sample_y;
				end else begin
					lpx_q      <= lpx_d;
					lpy_q      <= lpy_d;
					estx_q     <= estx_d;
					esty_q     <= esty_d;
					rate_x_out <= outx[23:8];
					rate_y_out <= outy[23:8];
				end
			end
		end
	end

	// ==========================================================
	// pulse-density outputs
	reg [9:0] pdm_cnt_q;
	reg       pdm_tick_q;

	always @(posedge clk_sys) begin
		if (!rst_b) begin
			pdm_cnt_q  <= 10'h000;
			pdm_tick_q <= 1'b0;
		end else if (pdm_cnt_q == PDM_LAST) begin
			pdm_cnt_q  <= 10'h000;
			pdm_tick_q <= 1'b1;
		end else begin
			pdm_cnt_q  <= pdm_cnt_q + 10'h001;
			pdm_tick_q <= 1'b0;
		end
	end

	rsf_pdm u_pdm_x (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.tick    (pdm_tick_q),
		.enable  (analog_lvl),
		.sample  (rate_x_out),
		.bit_q   (density_stream_out_x)
	);

	rsf_pdm u_pdm_y (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.tick    (pdm_tick_q),
		.enable  (analog_lvl),
		.sample  (rate_y_out),
		.bit_q   (density_stream_out_y)
	);

endmodule // rsf_top

`default_nettype wire

// ---- bench/rsf_assertions.sv ----
`default_nettype none
// ==========================================================
// port checks for rsf_top
module rsf_assertions #(
	parameter [23:0] SETTLE_CYCLES = 24'd50
) (
	input wire logic        clk_sys,
	input wire logic        rst_b,
	input wire logic        spi_sclk,
	input wire logic        spi_cs_b,
	input wire logic        spi_mosi,
	input wire logic        spi_miso,
	input wire logic        spi_miso_oe,
	input wire logic        interface_supply,
	input wire logic        analog_mode_sel,
	input wire logic        sample_valid,
	input wire logic [15:0] sample_x,
	input wire logic [15:0] sample_y,
	input wire logic [15:0] rate_x_out,
	input wire logic [15:0] rate_y_out,
	input wire logic        rate_update,
	input wire logic        measuring,
	input wire logic        offset_settled,
	input wire logic        temp_sensor_en,
	input wire logic        density_stream_out_x,
	input wire logic        density_stream_out_y
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	logic [23:0] mcnt_q;
	logic [9:0]  pcnt_q;
	logic        px_q;
	// ==========================================================
	// measuring age and stream bit age
	always @(posedge clk_sys) begin
		px_q <= rst_b & density_stream_out_x;
		if (!rst_b || !measuring) mcnt_q <= 24'h0;
		else if (mcnt_q != 24'hFFFFFF) mcnt_q <= mcnt_q + 24'h1;
		if (!rst_b || px_q != density_stream_out_x) pcnt_q <= 10'h0;
		else if (pcnt_q != 10'h3FF) pcnt_q <= pcnt_q + 10'h1;
	end
	// ==========================================================
	// checks
	property p_upd_cause; rate_update |-> $past(sample_valid) && $past(measuring); endproperty
	a_upd_cause: assert property (p_upd_cause) else $error("update without sample");
	property p_upd_follow; sample_valid && measuring |=> rate_update; endproperty
	a_upd_follow: assert property (p_upd_follow) else $error("sample not taken");
	property p_hold; !measuring ##1 !measuring |-> $stable(rate_x_out) && $stable(rate_y_out);
	endproperty
	a_hold: assert property (p_hold) else $error("rate moved in standby");
	property p_analog; analog_mode_sel [*8] |-> measuring; endproperty
	a_analog: assert property (p_analog) else $error("standby in analog mode");
	property p_bypass; analog_mode_sel [*8] ##0 sample_valid |=>
		rate_x_out == $past(sample_x) && rate_y_out == $past(sample_y); endproperty
	a_bypass: assert property (p_bypass) else $error("filter not bypassed");
	property p_pdm_rate; density_stream_out_x != px_q |-> pcnt_q >= 10'd690; endproperty
	a_pdm_rate: assert property (p_pdm_rate) else $error("stream bit too fast");
	property p_cs_idle; spi_cs_b [*8] |-> !spi_miso_oe; endproperty
	a_cs_idle: assert property (p_cs_idle) else $error("drive while deselected");
	property p_no_sup; !interface_supply [*8] |-> !spi_miso_oe && !measuring; endproperty
	a_no_sup: assert property (p_no_sup) else $error("active without supply");
	property p_settle; offset_settled && measuring |-> mcnt_q >= SETTLE_CYCLES; endproperty
	a_settle: assert property (p_settle) else $error("settled too early");
	property p_settle_by; mcnt_q == SETTLE_CYCLES + 24'd2 |-> offset_settled; endproperty
	a_settle_by: assert property (p_settle_by) else $error("settled too late");
endmodule // rsf_assertions
bind rsf_top rsf_assertions #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_rsf_assertions (
	.clk_sys(clk_sys), .rst_b(rst_b), .spi_sclk(spi_sclk), .spi_cs_b(spi_cs_b),
	.spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
	.interface_supply(interface_supply), .analog_mode_sel(analog_mode_sel),
	.sample_valid(sample_valid), .sample_x(sample_x), .sample_y(sample_y),
	.rate_x_out(rate_x_out), .rate_y_out(rate_y_out), .rate_update(rate_update),
	.measuring(measuring), .offset_settled(offset_settled), .temp_sensor_en(temp_sensor_en),
	.density_stream_out_x(density_stream_out_x), .density_stream_out_y(density_stream_out_y));
`default_nettype wire

// ---- bench/rsf_spi_master.sv ----
`default_nettype none
// ==========================================================
// serial master, mode 3
module rsf_spi_master (
	output var logic sclk,
	output var logic cs_b,
	output var logic mosi,
	input  wire logic miso
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		sclk = 1'b1;
		cs_b = 1'b1;
		mosi = 1'b1;
	end
	// header then n bytes from wd[31:24] down
	task automatic xfer(input logic [7:0] hdr, input int n, input logic [31:0] wd,
		output logic [31:0] rd);
		logic [39:0] sh;
		sh = {hdr, wd};
		rd = 32'h0;
		cs_b = 1'b0;
		// link edges kept off clock edges
		#251.3;
		for (int i = 0; i < 8 * (n + 1); i++) begin
			sclk = 1'b0;
			mosi = sh[39];
			sh = sh << 1;
			#62.5;
			sclk = 1'b1;
			rd = {rd[30:0], miso};
			#62.5;
		end
		#248.7;
		cs_b = 1'b1;
		mosi = ~mosi;
		#10000;
	endtask
endmodule // rsf_spi_master
`default_nettype wire

// ---- bench/rate_sensor_spi_mode_filter_tb.sv ----
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
	$display("[ERR] %0t got %h want %h", $time, a, b); end end
// ==========================================================
// bench top
module rate_sensor_spi_mode_filter_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_sys, rst_b, sclk, cs_b, mosi, miso, oe, sup, asel, sv;
	logic        upd, meas, settled, tsen, px, py;
	logic [15:0] sx, sy, rx, ry, pv;
	logic [31:0] r;
	logic [7:0]  v;
	int          seed, num_errors, n_tests, ox, oy;
	wire logic   miso_w = oe ? miso : 1'bx;
	rsf_top #(.SETTLE_CYCLES(24'd50)) u_rsf_top (
		.clk_sys(clk_sys), .rst_b(rst_b), .spi_sclk(sclk), .spi_cs_b(cs_b),
		.spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(oe), .interface_supply(sup),
		.analog_mode_sel(asel), .sample_valid(sv), .sample_x(sx), .sample_y(sy),
		.rate_x_out(rx), .rate_y_out(ry), .rate_update(upd), .measuring(meas),
		.offset_settled(settled), .temp_sensor_en(tsen),
		.density_stream_out_x(px), .density_stream_out_y(py));
	rsf_spi_master u_rsf_spi_master (.sclk(sclk), .cs_b(cs_b), .mosi(mosi), .miso(miso_w));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// ==========================================================
	// helpers
	function automatic logic [15:0] lp_exp(input int c);
		return 16'h1000 >> c;
	endfunction
	task automatic wr(input logic [6:0] a, input int n, input logic [31:0] d);
		logic [31:0] q;
		u_rsf_spi_master.xfer({1'b0, a}, n, d, q);
	endtask
	task automatic rd(input logic [6:0] a, input int n, output logic [31:0] q);
		u_rsf_spi_master.xfer({1'b1, a}, n, 32'h0, q);
	endtask
	task automatic smp(input logic [15:0] x, input int k);
		repeat (k) begin
			@(negedge clk_sys);
			sv = 1'b1;
			sx = x;
			sy = 16'($random(seed));
		end
		@(negedge clk_sys);
		sv = 1'b0;
		@(negedge clk_sys);
	endtask
	task automatic give_verdict;
		$display("tests %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		#900000;
		num_errors++;
		give_verdict();
	end
	// ==========================================================
	// scenarios
	initial begin
		seed = 41787;
		{rst_b, sup, asel, sv, sx, sy, num_errors, n_tests} = '0;
		repeat (4) @(negedge clk_sys);
		rst_b = 1'b1;
		wr(7'h10, 1, 32'h02000000);
		`CHK(meas, 1'b0)
		sup = 1'b1;
		rd(7'h10, 1, r);
		`CHK(r[7:0], 8'h00)
		rd(7'h11, 1, r);
		`CHK(r[7:0], 8'h00)
		rd(7'h20, 1, r);
		`CHK(r[7:0], 8'h00)
		wr(7'h10, 2, 32'h00370000);
		rd(7'h11, 1, r);
		`CHK(r[7:0], 8'h00)
		smp(16'h1234, 4);
		`CHK(rx, 16'h0000)
		wr(7'h10, 1, 32'h02000000);
		`CHK(meas, 1'b1)
		`CHK(settled, 1'b1)
		for (int c = 0; c < 8; c++) begin
			wr(7'h11, 1, {c[7:0], 24'h0});
			smp(16'h0000, 24 << (c + 1));
			smp(16'h2000, 1);
			`CHK(rx, lp_exp(c))
		end
		wr(7'h10, 2, 32'h036A0000);
		rd(7'h10, 2, r);
		`CHK(r[15:0], 16'h0362)
		`CHK(tsen, 1'b1)
		for (int i = 0; i < 4; i++) begin
			v = (i == 0) ? 8'hBD : 8'($random(seed));
			wr(7'h11, 1, {v, 24'h0});
			rd(7'h11, 1, r);
			`CHK(r[7:0], v & 8'hF7)
		end
		wr(7'h11, 1, 32'hA0000000);
		smp(16'h1000, 600);
		`CHK($signed(rx) < 16'sh0100 && $signed(rx) > -16'sh0100, 1'b1)
		pv = rx;
		wr(7'h11, 1, 32'h10000000);
		smp(16'h1000, 1);
		`CHK($signed(rx - pv) < 16'sh0010 && $signed(rx - pv) > -16'sh0010, 1'b1)
		wr(7'h10, 1, 32'h00000000);
		wr(7'h10, 1, 32'h02000000);
		smp(16'h1000, 4);
		`CHK($signed(rx) > 16'sh0800, 1'b1)
		asel = 1'b1;
		wr(7'h10, 1, 32'h00000000);
		`CHK(meas, 1'b1)
		@(negedge clk_sys);
		sv = 1'b1;
		sx = 16'h4000;
		sy = 16'hC000;
		@(negedge clk_sys);
		sv = 1'b0;
		@(negedge clk_sys);
		`CHK({rx, ry}, 32'h4000C000)
		rd(7'h08, 4, r);
		`CHK(r, 32'h004000C0)
		{ox, oy} = '0;
		repeat (16) begin
			repeat (694) @(negedge clk_sys);
			ox += px;
			oy += py;
		end
		`CHK(ox > 8 && oy < 8, 1'b1)
		give_verdict();
	end
endmodule // rate_sensor_spi_mode_filter_tb
`default_nettype wire
